// file: crbd_pkg.sv
// crbd_pkg: constants and carrier types for the clock, reset and bus-direction block
// assumes: one 250 MHz clock (the double-rate input) drives everything
//
// How it works
// RQ1 - core clock is the input clock divided by two
// RQ2 - core clock keeps toggling while reset is asserted
// RQ3 - core clock phase is fixed by the trailing edge of reset
// RQ4 - raw reset passes two flops; synchronized trailing edge aligns the phase
// RQ5 - 25-bit address bus driven for core or DMA chip-select accesses
// RQ6 - under external master the address bus is received and routed to decoders
// RQ7 - data bus received on ROM/PROM/IO fetches and external master writes
// RQ8 - data bus driven on IO writes and external master reads
// RQ9 - interrupt acknowledge neither drives nor samples the data bus
// RQ10 - raw reset pin resets core, registers and external devices
// RQ11 - software reset instruction leaves registers and processor state untouched
// RQ12 - clock source may slow the clock but never remove it
// RQ13 - on bus grant the read/write line becomes an input
// RQ14 - high-impedance and test inputs select three-state, input-pin or normal mode
// RQ15 - reset is synchronized and a synchronous reset output keeps clocks in phase
// RQ16 - divider forced to a defined state on detected reset release
`default_nettype none
package crbd_pkg;
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int UPPER_LO = 21; // address_lines index of A22 (bit 0 is A1)
    localparam int UPPER_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam int DIV_RATIO = 2;
    localparam logic CORE_CLK_RESET = 1'b0;
    localparam logic CORE_CLK_ALIGN = 1'b0;

    // ------------------------------------------------------------
    // pin-mode decode of high_impedance_select and test
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CRBD_MODE_TRISTATE = 2'b00,
        CRBD_MODE_INPUT_PIN = 2'b01,
        CRBD_MODE_NORMAL = 2'b10,
        CRBD_MODE_SPECIAL = 2'b11
    } crbd_mode_type;

    typedef enum logic [2:0] {
        CRBD_CYC_IDLE = 3'h0,
        CRBD_CYC_FETCH = 3'h1,
        CRBD_CYC_IO_WRITE = 3'h2,
        CRBD_CYC_INT_ACK = 3'h3,
        CRBD_CYC_ADDR_ONLY = 3'h4
    } crbd_cycle_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic rd_wr;
        logic addr_valid;
    } crbd_bus_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr_oe_n;
        logic data_oe_n;
        logic rd_wr_oe_n;
        logic strobe_oe_n;
        logic others_oe_n;
    } crbd_enable_type;
endpackage
`default_nettype wire

// file: crbd_reset_sync.sv
// crbd_reset_sync: two-stage synchronizer with release-edge detect
// assumes: raw input is asynchronous to sys_clk
`default_nettype none
module crbd_reset_sync
    import crbd_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic reset, // async reset, active high
    input wire logic raw_in_n, // raw active-low reset pin
    output logic sync_rst, // synchronized reset, active high
    output logic release_pulse // one cycle at the trailing edge
);
    logic [SYNC_STAGES-1:0] stage_q;
    logic sync_rst_q;

    // ------------------------------------------------------------
    // synchronizer: stage 0 feeds only stage 1
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            stage_q <= '1;
        end
        else
        begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], ~raw_in_n}; // RQ4
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sync_rst_q <= 1'b1;
        end
        else
        begin
            sync_rst_q <= stage_q[SYNC_STAGES-1]; // RQ15
        end
    end

    assign sync_rst = sync_rst_q;
    assign release_pulse = sync_rst_q & ~stage_q[SYNC_STAGES-1]; // RQ4

    a_release_once: assert property (@(posedge sys_clk) disable iff (reset)
        release_pulse |=> !release_pulse) // RQ4
        else $error("release pulse longer than one cycle");
endmodule
`default_nettype wire

// file: crbd_top.sv
// crbd_top: half-rate core clock generation and system bus direction control
// assumes: sys_clk is the double-rate input; core logic supplies cycle kind and bus ownership
`default_nettype none
module crbd_top
    import crbd_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int DATA_BITS = DATA_W
)
(
    input wire logic sys_clk, // double-rate input clock
    input wire logic reset, // async power-on reset, active high
    input wire logic raw_reset_in_n, // raw reset pin, active low
    input wire logic soft_reset_req, // reset instruction from core, pulse
    input wire logic high_impedance_select_n, // pin, active low
    input wire logic test_in, // test pin
    input wire logic bus_request_in_n, // pin, active low
    input wire logic bus_grant_out_n, // grant from arbiter, active low
    input wire logic cycle_active, // core or dma cycle running
    input wire crbd_cycle_type cycle_kind, // kind of internal cycle
    input wire logic ext_rd_wr, // rd_wr as seen by ext master, 1 read
    input wire crbd_bus_type core_bus, // internal address/data/strobe to drive
    input wire logic [ADDR_BITS-1:0] address_lines_i, // address pins in
    input wire logic [DATA_BITS-1:0] data_lines_i, // data pins in
    input wire logic rd_wr_i, // read/write pin in
    input wire logic address_valid_strobe_n_i, // strobe pin in, active low
    output logic half_rate_core_clock, // core clock out
    output logic sync_reset_out, // synchronous reset, active high
    output logic ext_device_reset_n, // reset to external devices, active low
    output logic [ADDR_BITS-1:0] address_lines_o, // address pins out
    output crbd_enable_type pin_oe_n, // output enables, low drives
    output logic [DATA_BITS-1:0] data_lines_o, // data pins out
    output logic rd_wr_o, // read/write pin out
    output logic address_valid_strobe_n_o, // strobe pin out, active low
    output logic [ADDR_BITS-1:0] decode_addr, // address to internal decoders
    output logic [DATA_BITS-1:0] read_data, // captured data bus
    output logic read_data_valid, // pulse, read_data updated
    output logic ext_rd_wr_seen, // ext master read/write, registered
    output logic ext_strobe_seen, // ext master strobe active, registered
    output crbd_mode_type pin_mode, // decoded pin mode, registered
    output logic bus_request_seen // synchronized bus request, active high
);
    // the carrier structs fix the pin widths, so other widths cannot be served
    if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W)
    begin : g_width_check
        $error("crbd_top: bus widths must match the pin widths");
    end

    // ------------------------------------------------------------
    // reset synchronizer
    // ------------------------------------------------------------
    logic sync_rst;
    logic release_pulse;

    crbd_reset_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .raw_in_n(raw_reset_in_n),
        .sync_rst(sync_rst),
        .release_pulse(release_pulse)
    );

    assign sync_reset_out = sync_rst; // RQ15
    // soft reset request deliberately has no effect on any state
    assign ext_device_reset_n = ~sync_rst; // RQ10 RQ11

    // ------------------------------------------------------------
    // half-rate clock divider
    // ------------------------------------------------------------
    logic core_clk_q;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            core_clk_q <= CORE_CLK_RESET;
        end
        else if (release_pulse)
        begin
            core_clk_q <= CORE_CLK_ALIGN; // RQ3 RQ16
        end
        else
        begin
            core_clk_q <= ~core_clk_q; // RQ1 RQ2
        end
    end

    assign half_rate_core_clock = core_clk_q;

    a_clock_toggles: assert property (@(posedge sys_clk) disable iff (reset)
        (sync_rst && !release_pulse) |=> (core_clk_q != $past(core_clk_q))) // RQ2
        else $error("core clock stopped during reset");
    a_phase_aligned: assert property (@(posedge sys_clk) disable iff (reset)
        release_pulse |=> (core_clk_q == CORE_CLK_ALIGN) ##1 (core_clk_q != CORE_CLK_ALIGN)) // RQ3
        else $error("core clock phase not aligned at reset release");
    a_half_rate: assert property (@(posedge sys_clk) disable iff (reset)
        (!release_pulse ##1 !release_pulse ##1 !release_pulse)
        |-> (core_clk_q == $past(core_clk_q, 2) && core_clk_q != $past(core_clk_q))) // RQ1
        else $error("core clock not at half rate");

    // ------------------------------------------------------------
    // pin synchronizers for mode straps and bus request
    // ------------------------------------------------------------
    logic [2:0] pins_meta_q;
    logic [2:0] pins_q;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pins_meta_q <= 3'h0;
            pins_q <= 3'h0;
        end
        else
        begin
            pins_meta_q <= {~bus_request_in_n, high_impedance_select_n, test_in};
            pins_q <= pins_meta_q;
        end
    end

    crbd_mode_type mode_q;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            mode_q <= CRBD_MODE_TRISTATE;
        end
        else
        begin
            mode_q <= crbd_mode_type'(pins_q[1:0]); // RQ14
        end
    end

    assign pin_mode = mode_q;
    assign bus_request_seen = pins_q[2];

    // ------------------------------------------------------------
    // direction decode
    // ------------------------------------------------------------
    logic granted;
    logic all_off;
    logic upper_off;
    logic drive_addr;
    logic drive_data;
    logic sample_data;

    assign granted = ~bus_grant_out_n;
    assign all_off = (mode_q != CRBD_MODE_NORMAL); // RQ14
    assign upper_off = all_off;
    assign drive_addr = cycle_active && !granted && (cycle_kind != CRBD_CYC_IDLE); // RQ5
    assign drive_data = granted ? ext_rd_wr
                      : (cycle_active && cycle_kind == CRBD_CYC_IO_WRITE); // RQ8 RQ9
    assign sample_data = granted ? (!ext_rd_wr && !address_valid_strobe_n_i)
                       : (cycle_active && cycle_kind == CRBD_CYC_FETCH); // RQ7 RQ9

    always_comb
    begin
        pin_oe_n = '1;
        if (!all_off)
        begin
            pin_oe_n.addr_oe_n = drive_addr ? '0 : '1; // RQ5 RQ6
            pin_oe_n.data_oe_n = ~drive_data; // RQ8
            pin_oe_n.rd_wr_oe_n = granted || !cycle_active; // RQ13
            pin_oe_n.strobe_oe_n = granted || !cycle_active;
            pin_oe_n.others_oe_n = 1'b0;
        end
        if (upper_off)
        begin
            pin_oe_n.addr_oe_n[UPPER_LO +: UPPER_W] = '1; // RQ14
        end
    end

    // ------------------------------------------------------------
    // registered pin outputs and captured inputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            address_lines_o <= '0;
            data_lines_o <= '0;
            rd_wr_o <= 1'b1;
            address_valid_strobe_n_o <= 1'b1;
        end
        else
        begin
            address_lines_o <= core_bus.addr; // RQ5
            data_lines_o <= core_bus.data;
            rd_wr_o <= core_bus.rd_wr;
            address_valid_strobe_n_o <= ~(core_bus.addr_valid && cycle_active);
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            decode_addr <= '0;
            ext_rd_wr_seen <= 1'b1;
            ext_strobe_seen <= 1'b0;
        end
        else
        begin
            decode_addr <= granted ? address_lines_i : core_bus.addr; // RQ6
            ext_rd_wr_seen <= rd_wr_i;
            ext_strobe_seen <= granted && !address_valid_strobe_n_i;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            read_data <= '0;
            read_data_valid <= 1'b0;
        end
        else
        begin
            read_data_valid <= sample_data; // RQ7 RQ9
            if (sample_data)
            begin
                read_data <= data_lines_i;
            end
        end
    end

    a_intack_quiet: assert property (@(posedge sys_clk) disable iff (reset)
        (!granted && cycle_active && cycle_kind == CRBD_CYC_INT_ACK)
        |-> (pin_oe_n.data_oe_n && !sample_data)) // RQ9
        else $error("data bus used during interrupt acknowledge");
    a_grant_releases: assert property (@(posedge sys_clk) disable iff (reset)
        granted |-> (pin_oe_n.rd_wr_oe_n && (&pin_oe_n.addr_oe_n))) // RQ13
        else $error("read/write or address driven while granted");
    a_mode_tristate: assert property (@(posedge sys_clk) disable iff (reset)
        (mode_q != CRBD_MODE_NORMAL) |-> (pin_oe_n == '1)) // RQ14
        else $error("outputs driven outside normal mode");
    a_io_write_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (mode_q == CRBD_MODE_NORMAL && !granted && cycle_active && cycle_kind == CRBD_CYC_IO_WRITE)
        |-> !pin_oe_n.data_oe_n) // RQ8
        else $error("data bus not driven on io write");
    a_fetch_capture: assert property (@(posedge sys_clk) disable iff (reset)
        (!granted && cycle_active && cycle_kind == CRBD_CYC_FETCH)
        |=> (read_data_valid && read_data == $past(data_lines_i))) // RQ7
        else $error("fetch data not captured");
    a_ext_addr_route: assert property (@(posedge sys_clk) disable iff (reset)
        granted |=> (decode_addr == $past(address_lines_i))) // RQ6
        else $error("external address not routed to decoders");
    a_core_addr_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (mode_q == CRBD_MODE_NORMAL && drive_addr) |-> (pin_oe_n.addr_oe_n == '0)) // RQ5
        else $error("address not driven on core cycle");
    a_device_reset: assert property (@(posedge sys_clk) disable iff (reset)
        (!raw_reset_in_n ##1 !raw_reset_in_n ##1 !raw_reset_in_n) |=> !ext_device_reset_n) // RQ10
        else $error("external devices not reset by reset pin");
endmodule
`default_nettype wire

// file: crbd_bus_partner.sv
// crbd_bus_partner: memory and external bus master on the far side of the system bus
// assumes: pin outputs and enables come from crbd_top; bench steers master ownership
`default_nettype none
module crbd_bus_partner
    import crbd_pkg::*;
#(
    parameter logic [DATA_W-1:0] MEM_KEY = 16'h5a5a
)
(
    input wire logic sys_clk, // clock
    input wire crbd_enable_type pin_oe_n, // device enables, low drives
    input wire logic [ADDR_W-1:0] address_lines_o, // device address out
    input wire logic [DATA_W-1:0] data_lines_o, // device data out
    input wire logic rd_wr_o, // device read/write out
    input wire logic address_valid_strobe_n_o, // device strobe out
    input wire logic master_en, // far side owns the bus
    input wire logic mst_read, // master cycle is a read
    input wire logic [ADDR_W-1:0] mst_addr, // master address
    input wire logic [DATA_W-1:0] mst_data, // master write data
    output logic [ADDR_W-1:0] address_lines_i, // address wire
    output logic [DATA_W-1:0] data_lines_i, // data wire
    output logic rd_wr_i, // read/write wire, pulled up
    output logic address_valid_strobe_n_i // strobe wire, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // released address and data lines with no other source carry a pattern that flips each cycle
    // ----------------------------------------
    logic [ADDR_W-1:0] noise_q = 25'h0aaaaaa;
    always_ff @(posedge sys_clk)
    begin
        noise_q <= ~noise_q;
    end
    always_comb
    begin
        for (int i = 0; i < ADDR_W; i++)
        begin
            address_lines_i[i] = !pin_oe_n.addr_oe_n[i] ? address_lines_o[i] : master_en ? mst_addr[i] : noise_q[i];
        end
        rd_wr_i = !pin_oe_n.rd_wr_oe_n ? rd_wr_o : master_en ? mst_read : 1'b1;
        address_valid_strobe_n_i = !pin_oe_n.strobe_oe_n ? address_valid_strobe_n_o : !master_en;
        if (!pin_oe_n.data_oe_n)
            data_lines_i = data_lines_o;
        else if (master_en && !mst_read)
            data_lines_i = mst_data;
        else if (!master_en && rd_wr_i)
            data_lines_i = address_lines_i[DATA_W-1:0] ^ MEM_KEY;
        else
            data_lines_i = noise_q[DATA_W-1:0];
    end
endmodule
`default_nettype wire

// file: tb.sv
// tb: self-checking bench for crbd_top with a bus partner model
// assumes: one 250 MHz clock; inputs change on the falling edge
`default_nettype none
module tb
    import crbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DATA_W-1:0] KEY = 16'h5a5a;
    localparam logic [31:0] ALL_OFF = (32'h1 << $bits(crbd_enable_type)) - 32'h1;
    logic sys_clk, reset, raw_reset_in_n, soft_reset_req, high_impedance_select_n, test_in;
    logic bus_request_in_n, bus_grant_out_n, cycle_active, ext_rd_wr, rd_wr_i, address_valid_strobe_n_i;
    crbd_cycle_type cycle_kind;
    crbd_bus_type core_bus;
    crbd_enable_type pin_oe_n;
    crbd_mode_type pin_mode;
    logic [ADDR_W-1:0] address_lines_i, address_lines_o, decode_addr, mst_addr;
    logic [DATA_W-1:0] data_lines_i, data_lines_o, read_data, mst_data;
    logic half_rate_core_clock, sync_reset_out, ext_device_reset_n, rd_wr_o, address_valid_strobe_n_o;
    logic read_data_valid, ext_rd_wr_seen, ext_strobe_seen, bus_request_seen, master_en, mst_read, prev;
    logic [DATA_W-1:0] exp_q[$];
    int fail_count = 0;
    int cmp_count = 0;
    int seed = 32'hd7e1;
    int n;
    crbd_top dut (.sys_clk(sys_clk), .reset(reset), .raw_reset_in_n(raw_reset_in_n),
        .soft_reset_req(soft_reset_req), .high_impedance_select_n(high_impedance_select_n), .test_in(test_in),
        .bus_request_in_n(bus_request_in_n), .bus_grant_out_n(bus_grant_out_n), .cycle_active(cycle_active),
        .cycle_kind(cycle_kind), .ext_rd_wr(ext_rd_wr), .core_bus(core_bus), .address_lines_i(address_lines_i),
        .data_lines_i(data_lines_i), .rd_wr_i(rd_wr_i), .address_valid_strobe_n_i(address_valid_strobe_n_i),
        .half_rate_core_clock(half_rate_core_clock), .sync_reset_out(sync_reset_out),
        .ext_device_reset_n(ext_device_reset_n), .address_lines_o(address_lines_o), .pin_oe_n(pin_oe_n),
        .data_lines_o(data_lines_o), .rd_wr_o(rd_wr_o), .address_valid_strobe_n_o(address_valid_strobe_n_o),
        .decode_addr(decode_addr), .read_data(read_data), .read_data_valid(read_data_valid),
        .ext_rd_wr_seen(ext_rd_wr_seen), .ext_strobe_seen(ext_strobe_seen), .pin_mode(pin_mode),
        .bus_request_seen(bus_request_seen));
    crbd_bus_partner #(.MEM_KEY(KEY)) partner (.sys_clk(sys_clk), .pin_oe_n(pin_oe_n),
        .address_lines_o(address_lines_o), .data_lines_o(data_lines_o), .rd_wr_o(rd_wr_o),
        .address_valid_strobe_n_o(address_valid_strobe_n_o), .master_en(master_en), .mst_read(mst_read),
        .mst_addr(mst_addr), .mst_data(mst_data), .address_lines_i(address_lines_i),
        .data_lines_i(data_lines_i), .rd_wr_i(rd_wr_i), .address_valid_strobe_n_i(address_valid_strobe_n_i));
    // ----------------------------------------
    // clock never removed, so the core clock keeps toggling
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // counts edges until sync_reset_out reaches val, checking the core clock keeps toggling
    task automatic wait_sync(input logic val);
        n = 0;
        do
        begin
            prev = half_rate_core_clock;
            @(negedge sys_clk);
            n++;
            if (sync_reset_out !== val)
                chk("core clock toggles", 32'(half_rate_core_clock ^ prev), 32'h1);
        end while (sync_reset_out !== val && n < 8);
        if (sync_reset_out !== val)
        begin
            fail_count++;
            end_sim();
        end
    endtask
    // ----------------------------------------
    // result watcher: each captured word matches the oldest note
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        #1;
        if (read_data_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected capture", 32'h1, 32'h0);
            else
                chk("read_data", 32'(read_data), 32'(exp_q.pop_front()));
        end
    end
    initial
    begin
        {reset, raw_reset_in_n, high_impedance_select_n, bus_request_in_n, bus_grant_out_n} = 5'h1f;
        {soft_reset_req, test_in, cycle_active, ext_rd_wr, master_en, mst_read} = 6'h00;
        cycle_kind = CRBD_CYC_IDLE;
        core_bus = '0;
        mst_addr = '0;
        mst_data = '0;
        repeat (16) @(negedge sys_clk);
        chk("reset core clock", 32'(half_rate_core_clock), 32'h0);
        chk("reset ext device", 32'({sync_reset_out, ext_device_reset_n}), 32'h2);
        chk("reset enables", 32'(pin_oe_n), ALL_OFF);
        reset = 1'b0;
        wait_sync(1'b0);
        for (int i = 0; i < 4; i++)
        begin
            prev = half_rate_core_clock;
            @(negedge sys_clk);
            chk("half rate", 32'(half_rate_core_clock ^ prev), 32'h1);
        end
        $display("test clock after reset done");
        raw_reset_in_n = 1'b0;
        wait_sync(1'b1);
        chk("sync assert delay", 32'(n), 32'h3);
        chk("ext device reset", 32'(ext_device_reset_n), 32'h0);
        // one extra cycle: release then lands where a plain toggle would give 1
        @(negedge sys_clk);
        raw_reset_in_n = 1'b1;
        wait_sync(1'b0);
        chk("sync release delay", 32'(n), 32'h3);
        chk("phase at release", 32'(half_rate_core_clock), 32'h0);
        @(negedge sys_clk);
        chk("phase after release", 32'(half_rate_core_clock), 32'h1);
        soft_reset_req = 1'b1;
        @(negedge sys_clk);
        soft_reset_req = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("soft reset ignored", 32'({sync_reset_out, ext_device_reset_n}), 32'h1);
        $display("test reset pin done");
        cycle_active = 1'b1;
        cycle_kind = CRBD_CYC_ADDR_ONLY;
        for (int m = 0; m < 4; m++)
        begin
            {high_impedance_select_n, test_in} = 2'(m);
            repeat (4) @(negedge sys_clk);
            chk("pin mode", 32'(pin_mode), 32'(m));
            if (m == 2)
                chk("normal addr drive", 32'(pin_oe_n.addr_oe_n), 32'h0);
            else
                chk("three-state", 32'(pin_oe_n), ALL_OFF);
        end
        {high_impedance_select_n, test_in} = 2'b10;
        repeat (4) @(negedge sys_clk);
        $display("test pin modes done");
        for (int i = 0; i < 4; i++)
        begin
            core_bus.addr = 25'($random(seed));
            core_bus.rd_wr = 1'b1;
            core_bus.addr_valid = 1'b1;
            cycle_active = 1'b0;
            @(negedge sys_clk);
            cycle_active = 1'b1;
            cycle_kind = CRBD_CYC_FETCH;
            exp_q.push_back(core_bus.addr[DATA_W-1:0] ^ KEY);
            #1;
            chk("fetch addr drive", 32'(pin_oe_n.addr_oe_n), 32'h0);
            chk("fetch data recv", 32'(pin_oe_n.data_oe_n), 32'h1);
            @(negedge sys_clk);
            chk("address out", 32'(address_lines_o), 32'(core_bus.addr));
            chk("fetch rd_wr strobe", 32'({rd_wr_o, address_valid_strobe_n_o}), 32'h2);
        end
        core_bus.data = 16'($random(seed));
        core_bus.rd_wr = 1'b0;
        cycle_kind = CRBD_CYC_IO_WRITE;
        #1;
        chk("io write drive", 32'(pin_oe_n.data_oe_n), 32'h0);
        @(negedge sys_clk);
        chk("io write data", 32'(data_lines_o), 32'(core_bus.data));
        chk("io write rd_wr strobe", 32'({rd_wr_o, address_valid_strobe_n_o}), 32'h0);
        cycle_kind = CRBD_CYC_INT_ACK;
        #1;
        chk("int ack no drive", 32'(pin_oe_n.data_oe_n), 32'h1);
        repeat (2) @(negedge sys_clk);
        $display("test core cycles done");
        cycle_active = 1'b0;
        cycle_kind = CRBD_CYC_IDLE;
        {bus_request_in_n, bus_grant_out_n, master_en} = 3'b001;
        mst_addr = 25'($random(seed));
        mst_data = 16'($random(seed));
        exp_q.push_back(mst_data);
        #1;
        chk("granted addr", 32'(pin_oe_n.addr_oe_n), 32'(ALL_OFF[ADDR_W-1:0]));
        chk("granted rd_wr", 32'({pin_oe_n.rd_wr_oe_n, pin_oe_n.strobe_oe_n}), 32'h3);
        @(negedge sys_clk);
        chk("decode addr", 32'(decode_addr), 32'(mst_addr));
        chk("ext write seen", 32'({ext_rd_wr_seen, ext_strobe_seen}), 32'h1);
        {mst_read, ext_rd_wr} = 2'b11;
        #1;
        chk("ext read drive", 32'(pin_oe_n.data_oe_n), 32'h0);
        @(negedge sys_clk);
        chk("ext read seen", 32'({bus_request_seen, ext_rd_wr_seen, ext_strobe_seen}), 32'h7);
        {bus_request_in_n, bus_grant_out_n, master_en, mst_read, ext_rd_wr} = 5'b11000;
        repeat (3) @(negedge sys_clk);
        chk("notes drained", 32'(exp_q.size()), 32'h0);
        $display("test external master done");
        end_sim();
    end
endmodule
`default_nettype wire
